//--- hdl/evbank_pkg.sv
// constants for the event-input bank selector; its synchroniser uses none of them
// assumes a single 50 MHz clock domain and an APB master with 32-bit data
package evbank_pkg;

   // ------------------------------------------------------------------
   // sizes
   // ------------------------------------------------------------------
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   localparam int NUM_CHAN = 2;
   localparam int NUM_EVENT = 2;
   localparam int NUM_BANKS = 4;
   localparam int NUM_PARAMS = 8;
   localparam int PARAM_W = 16;
   localparam int CODE_W = 7;
   localparam int SYNC_STAGES = 3;
   localparam int CLK_MHZ = 50;

   // ------------------------------------------------------------------
   // register offsets (byte addresses)
   // ------------------------------------------------------------------
   localparam logic [11:0] OFF_ASSIGN_ONE = 12'h000;
   localparam logic [11:0] OFF_ASSIGN_TWO = 12'h004;
   localparam logic [11:0] OFF_CONTROL = 12'h008;
   localparam logic [11:0] OFF_COMMAND = 12'h00C;
   localparam logic [11:0] OFF_STATUS = 12'h010;
   localparam logic [11:0] OFF_APPLIED = 12'h014;
   // parameter windows: base | window<<6 | chan<<5 | param<<2
   localparam logic [2:0] BANK_AREA_TAG = 3'h2;
   localparam logic [2:0] PRESENT_WINDOW = 3'h4;

   // ------------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------------
   localparam int CTRL_SOFT_RESET_BIT = 0;
   localparam int CTRL_FAR_SP_BIT = 1;
   localparam int CMD_BANK_LSB = 0;
   localparam int CMD_SET_BANK_BIT = 2;
   localparam int CMD_SET_RUN_BIT = 3;
   localparam int CMD_RUN_VALUE_BIT = 4;
   localparam int CMD_CHAN_BIT = 8;
   localparam int STAT_BANK_LSB = 0;
   localparam int STAT_RUN_LSB = 4;
   localparam int STAT_MANUAL_LSB = 6;
   localparam int STAT_REMOTE_LSB = 8;
   localparam int STAT_LEVEL_LSB = 10;
   localparam int APPLIED_TWO_LSB = 8;

   // ------------------------------------------------------------------
   // reset values and assignment codes
   // ------------------------------------------------------------------
   localparam logic [6:0] ASSIGN_RESET = 7'h00;
   localparam logic [6:0] ASSIGN_MAX = 7'h45;
   localparam logic [6:0] TARGET_STRIDE = 7'h0A;
   localparam logic [6:0] FUNC_LAST = 7'h06;
   localparam logic [1:0] BANK_RESET = 2'h0;
   localparam logic FAR_SP_RESET = 1'b0;

   typedef enum logic [2:0] {
      FN_OFF = 3'h0,
      FN_BANK_BIT0 = 3'h1,
      FN_BANK_BIT1 = 3'h2,
      FN_STOP_RUN = 3'h3,
      FN_RUN_STOP = 3'h4,
      FN_AUTO_MANUAL = 3'h5,
      FN_LOCAL_REMOTE = 3'h6
   } evfunc_type;

endpackage

//--- hdl/event_sync_edge.sv
// three-stage synchroniser with agreement filter and edge pulse
// assumes an asynchronous pin input; output is on the CLK_IN domain
`timescale 1ns/10ps
module event_sync_edge (
   // clock and reset
   input wire logic clk_in,
   input wire logic arst_n_in,
   input wire logic ce_in,
   // pin
   input wire logic pin_in,
   // filtered result
   output logic level_out,
   output logic edge_out
);

   logic s1;
   logic s2;
   logic s3;

   // ------------------------------------------------------------------
   // synchroniser: s1 is read only by s2
   // ------------------------------------------------------------------
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         s1 <= 1'b0;
         s2 <= 1'b0;
         s3 <= 1'b0;
      end else if (ce_in) begin
         s1 <= pin_in;
         s2 <= s1;
         s3 <= s2;
      end
   end

   // both directions of change count, each exactly once
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         level_out <= 1'b0;
         edge_out <= 1'b0;
      end else if (ce_in) begin
         edge_out <= 1'b0;
         if (s2 == s3 && s3 != level_out) begin
            level_out <= s3;
            edge_out <= 1'b1;
         end
      end
   end

   property p_edge_both;
      @(posedge clk_in) disable iff (!arst_n_in)
      (ce_in && s2 == s3 && s3 != level_out)
         |=> (edge_out && level_out == $past(s3));
   endproperty
   a_edge_both: assert property (p_edge_both)
      else $error("event change not reported as edge");

endmodule // event_sync_edge

//--- hdl/event_bank_select.sv
// event-input bank and mode selector for a two-channel controller
// assumes an APB master on CLK_IN and raw switch levels on the event pins
//
// Function
// - each channel keeps four independent banks of control parameters
// - present-bank window follows selected bank; fixed windows reach banks 0-3
// - bank switchable by event input, internal bus, or operation command
// - bank index is input two times two plus input one
// - input one alone toggles between bank zero and bank one
// - read-only monitor shows each channel's selected bank, zero to three
// - exactly two event inputs, each with its own assignment
// - assignment targets all or one channel; seven selectable functions
// - assignment codes 0 to 69, zero after reset
// - assignments written only when stopped; applied at soft reset
// - both rising and falling event edges switch operation
// - stop/run, run/stop, auto/manual, local/remote follow input level
// - remote set point switching works only with permit set
//
// Design decisions made here: the APB register port and the address map.
`timescale 1ns/10ps
module event_bank_select (
   // clock, reset, enable
   input wire logic CLK_IN,
   input wire logic ARST_N_IN,
   input wire logic CE_IN,
   // apb slave
   input wire logic PSEL_IN,
   input wire logic PENABLE_IN,
   input wire logic PWRITE_IN,
   input wire logic [evbank_pkg::ADDR_W-1:0] PADDR_IN,
   input wire logic [evbank_pkg::DATA_W-1:0] PWDATA_IN,
   output logic PREADY_OUT,
   output logic [evbank_pkg::DATA_W-1:0] PRDATA_OUT,
   output logic PSLVERR_OUT,
   // event pins
   input wire logic EVENT_INPUT_ONE_IN,
   input wire logic EVENT_INPUT_TWO_IN,
   // internal bus bank request, same clock
   input wire logic [1:0] BUS_BANK_IN,
   input wire logic BUS_BANK_STB_IN,
   // channel state
   output logic [evbank_pkg::NUM_CHAN*2-1:0] BANK_OUT,
   output logic [evbank_pkg::NUM_CHAN-1:0] RUN_OUT,
   output logic [evbank_pkg::NUM_CHAN-1:0] MANUAL_OUT,
   output logic [evbank_pkg::NUM_CHAN-1:0] REMOTE_OUT
);

   localparam int NC = evbank_pkg::NUM_CHAN;
   localparam int NE = evbank_pkg::NUM_EVENT;
   localparam int MEM_WORDS =
      evbank_pkg::NUM_CHAN * evbank_pkg::NUM_BANKS * evbank_pkg::NUM_PARAMS;

   // ------------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------------
   function automatic logic [5:0] mem_index(input logic ch,
      input logic [1:0] bk, input logic [2:0] par);
      mem_index = {ch, bk, par};
   endfunction

   // code = target * 10 + function; target 0 is all channels
   function automatic evbank_pkg::evfunc_type decode_func(
      input logic [6:0] code, input int ch);
      logic [6:0] tgt;
      logic [6:0] fsel;
      tgt = code / evbank_pkg::TARGET_STRIDE;
      fsel = code % evbank_pkg::TARGET_STRIDE;
      if (fsel > evbank_pkg::FUNC_LAST ||
          (tgt != 7'h00 && tgt != 7'(ch + 1)))
         decode_func = evbank_pkg::FN_OFF;
      else
         decode_func = evbank_pkg::evfunc_type'(fsel[2:0]);
   endfunction

   // ------------------------------------------------------------------
   // state
   // ------------------------------------------------------------------
   logic [NC-1:0][1:0] bank;
   logic [NC-1:0] run;
   logic [NC-1:0] manual;
   logic [NC-1:0] remote;
   logic [NC-1:0][1:0] next_bank;
   logic [NC-1:0] next_run;
   logic [NC-1:0] next_manual;
   logic [NC-1:0] next_remote;
   logic [6:0] pending [NE];
   logic [6:0] applied [NE];
   logic far_sp;
   logic [evbank_pkg::PARAM_W-1:0] param_mem [MEM_WORDS];
   logic [NE-1:0] lvl;
   logic [NE-1:0] edge_seen;
   evbank_pkg::evfunc_type fn [NC][NE];

   // ------------------------------------------------------------------
   // event inputs, two of them
   // ------------------------------------------------------------------
   event_sync_edge u_sync_one (
      .clk_in(CLK_IN),
      .arst_n_in(ARST_N_IN),
      .ce_in(CE_IN),
      .pin_in(EVENT_INPUT_ONE_IN),
      .level_out(lvl[0]),
      .edge_out(edge_seen[0])
   );

   event_sync_edge u_sync_two (
      .clk_in(CLK_IN),
      .arst_n_in(ARST_N_IN),
      .ce_in(CE_IN),
      .pin_in(EVENT_INPUT_TWO_IN),
      .level_out(lvl[1]),
      .edge_out(edge_seen[1])
   );

   // ------------------------------------------------------------------
   // apb decode
   // ------------------------------------------------------------------
   logic setup;
   logic commit;
   logic wr_ok;
   logic bank_area;
   logic [2:0] win;
   logic acc_ch;
   logic [1:0] acc_bank;
   logic [5:0] acc_idx;
   logic [evbank_pkg::DATA_W-1:0] rd_word;
   logic bad_access;
   logic soft_rst_stb;
   logic cmd_stb;
   logic cmd_ch;

   assign setup = PSEL_IN && !PENABLE_IN;
   assign commit = PSEL_IN && PENABLE_IN && PREADY_OUT;
   // the error flag was latched from the same held request
   assign wr_ok = commit && PWRITE_IN && !PSLVERR_OUT;
   assign win = PADDR_IN[8:6];
   assign bank_area = PADDR_IN[11:9] == evbank_pkg::BANK_AREA_TAG &&
                      win <= evbank_pkg::PRESENT_WINDOW;
   assign acc_ch = PADDR_IN[5];
   // present window redirects to the channel's live bank
   assign acc_bank = (win == evbank_pkg::PRESENT_WINDOW) ?
                     bank[acc_ch] : win[1:0];
   assign acc_idx = mem_index(acc_ch, acc_bank, PADDR_IN[4:2]);
   assign soft_rst_stb = wr_ok && !bank_area &&
      PADDR_IN == evbank_pkg::OFF_CONTROL &&
      PWDATA_IN[evbank_pkg::CTRL_SOFT_RESET_BIT];
   assign cmd_stb = wr_ok && !bank_area &&
                    PADDR_IN == evbank_pkg::OFF_COMMAND;
   assign cmd_ch = PWDATA_IN[evbank_pkg::CMD_CHAN_BIT];

   always_comb begin
      rd_word = '0;
      bad_access = 1'b0;
      if (bank_area) begin
         rd_word[evbank_pkg::PARAM_W-1:0] = param_mem[acc_idx];
      end else begin
         case (PADDR_IN)
            evbank_pkg::OFF_ASSIGN_ONE: begin
               rd_word[6:0] = pending[0];
               // writes refused while running or out of range
               bad_access = PWRITE_IN && ((|run) ||
                  PWDATA_IN[6:0] > evbank_pkg::ASSIGN_MAX);
            end
            evbank_pkg::OFF_ASSIGN_TWO: begin
               rd_word[6:0] = pending[1];
               bad_access = PWRITE_IN && ((|run) ||
                  PWDATA_IN[6:0] > evbank_pkg::ASSIGN_MAX);
            end
            evbank_pkg::OFF_CONTROL: begin
               rd_word[evbank_pkg::CTRL_FAR_SP_BIT] = far_sp;
            end
            evbank_pkg::OFF_COMMAND: begin
               rd_word = '0;
            end
            evbank_pkg::OFF_STATUS: begin
               // bank monitor is read-only
               rd_word[evbank_pkg::STAT_BANK_LSB +: 4] = bank;
               rd_word[evbank_pkg::STAT_RUN_LSB +: 2] = run;
               rd_word[evbank_pkg::STAT_MANUAL_LSB +: 2] = manual;
               rd_word[evbank_pkg::STAT_REMOTE_LSB +: 2] = remote;
               rd_word[evbank_pkg::STAT_LEVEL_LSB +: 2] = lvl;
               bad_access = PWRITE_IN;
            end
            evbank_pkg::OFF_APPLIED: begin
               rd_word[6:0] = applied[0];
               rd_word[evbank_pkg::APPLIED_TWO_LSB +: 7] = applied[1];
               bad_access = PWRITE_IN;
            end
            default: begin
               bad_access = 1'b1;
            end
         endcase
      end
   end

   // zero-wait slave: answer is ready in the first access cycle
   always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         PREADY_OUT <= 1'b0;
         PRDATA_OUT <= '0;
         PSLVERR_OUT <= 1'b0;
      end else if (CE_IN) begin
         PREADY_OUT <= setup;
         if (setup) begin
            PRDATA_OUT <= PWRITE_IN ? '0 : rd_word;
            PSLVERR_OUT <= bad_access;
         end else if (commit) begin
            PSLVERR_OUT <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------------
   // parameter banks, four per channel
   // ------------------------------------------------------------------
   always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         for (int i = 0; i < MEM_WORDS; i++) begin
            param_mem[i] <= '0;
         end
      end else if (CE_IN && wr_ok && bank_area) begin
         param_mem[acc_idx] <= PWDATA_IN[evbank_pkg::PARAM_W-1:0];
      end
   end

   // ------------------------------------------------------------------
   // assignments: staged, then taken over at soft reset
   // ------------------------------------------------------------------
   always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         for (int i = 0; i < NE; i++) begin
            pending[i] <= evbank_pkg::ASSIGN_RESET;
            applied[i] <= evbank_pkg::ASSIGN_RESET;
         end
         far_sp <= evbank_pkg::FAR_SP_RESET;
      end else if (CE_IN) begin
         if (wr_ok && !bank_area) begin
            if (PADDR_IN == evbank_pkg::OFF_ASSIGN_ONE)
               pending[0] <= PWDATA_IN[6:0];
            if (PADDR_IN == evbank_pkg::OFF_ASSIGN_TWO)
               pending[1] <= PWDATA_IN[6:0];
            if (PADDR_IN == evbank_pkg::OFF_CONTROL)
               far_sp <= PWDATA_IN[evbank_pkg::CTRL_FAR_SP_BIT];
         end
         if (soft_rst_stb) begin
            applied[0] <= pending[0];
            applied[1] <= pending[1];
         end
      end
   end

   // ------------------------------------------------------------------
   // per-channel selection; event edges win over bus, bus over command
   // ------------------------------------------------------------------
   always_comb begin
      logic b0;
      logic b1;
      logic bank_ev;
      b0 = 1'b0;
      b1 = 1'b0;
      bank_ev = 1'b0;
      for (int c = 0; c < NC; c++) begin
         for (int i = 0; i < NE; i++) begin
            fn[c][i] = decode_func(applied[i], c);
         end
      end
      for (int c = 0; c < NC; c++) begin
         next_bank[c] = bank[c];
         next_run[c] = run[c];
         next_manual[c] = manual[c];
         next_remote[c] = remote[c];
         // operation command and internal bus as bank sources
         if (cmd_stb && cmd_ch == c[0]) begin
            if (PWDATA_IN[evbank_pkg::CMD_SET_BANK_BIT])
               next_bank[c] = PWDATA_IN[evbank_pkg::CMD_BANK_LSB +: 2];
            if (PWDATA_IN[evbank_pkg::CMD_SET_RUN_BIT])
               next_run[c] = PWDATA_IN[evbank_pkg::CMD_RUN_VALUE_BIT];
         end
         if (BUS_BANK_STB_IN)
            next_bank[c] = BUS_BANK_IN;
         b0 = 1'b0;
         b1 = 1'b0;
         bank_ev = 1'b0;
         for (int i = 0; i < NE; i++) begin
            // a bit with no input assigned reads as zero
            if (fn[c][i] == evbank_pkg::FN_BANK_BIT0) begin
               b0 = lvl[i];
               bank_ev = bank_ev || edge_seen[i];
            end
            if (fn[c][i] == evbank_pkg::FN_BANK_BIT1) begin
               b1 = lvl[i];
               bank_ev = bank_ev || edge_seen[i];
            end
         end
         if (bank_ev)
            next_bank[c] = {b1, b0};
         for (int i = 0; i < NE; i++) begin
            // FN_OFF falls through every case untouched
            if (edge_seen[i]) begin
               case (fn[c][i])
                  evbank_pkg::FN_STOP_RUN: next_run[c] = lvl[i];
                  evbank_pkg::FN_RUN_STOP: next_run[c] = !lvl[i];
                  evbank_pkg::FN_AUTO_MANUAL: next_manual[c] = lvl[i];
                  evbank_pkg::FN_LOCAL_REMOTE: begin
                     if (far_sp)
                        next_remote[c] = lvl[i];
                  end
                  default: begin
                  end
               endcase
            end
         end
      end
   end

   always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         for (int c = 0; c < NC; c++) begin
            bank[c] <= evbank_pkg::BANK_RESET;
         end
         run <= '0;
         manual <= '0;
         remote <= '0;
      end else if (CE_IN) begin
         bank <= next_bank;
         run <= next_run;
         manual <= next_manual;
         remote <= next_remote;
      end
   end

   assign BANK_OUT = bank;
   assign RUN_OUT = run;
   assign MANUAL_OUT = manual;
   assign REMOTE_OUT = remote;

   // ------------------------------------------------------------------
   // checks
   // ------------------------------------------------------------------
   sequence s_setup_to(logic [11:0] a, logic w);
      CE_IN && setup && !bank_area && PADDR_IN == a && PWRITE_IN == w;
   endsequence

   property p_bank_map;
      @(posedge CLK_IN) disable iff (!ARST_N_IN)
      (CE_IN && edge_seen[0] && fn[0][0] == evbank_pkg::FN_BANK_BIT0 &&
       fn[0][1] == evbank_pkg::FN_BANK_BIT1)
         |=> bank[0] == {$past(lvl[1]), $past(lvl[0])};
   endproperty
   a_bank_map: assert property (p_bank_map)
      else $error("bank does not follow both event inputs");

   property p_bank_alone;
      @(posedge CLK_IN) disable iff (!ARST_N_IN)
      (CE_IN && edge_seen[0] && fn[0][0] == evbank_pkg::FN_BANK_BIT0 &&
       fn[0][1] != evbank_pkg::FN_BANK_BIT1 &&
       fn[0][1] != evbank_pkg::FN_BANK_BIT0)
         |=> bank[0] == {1'b0, $past(lvl[0])};
   endproperty
   a_bank_alone: assert property (p_bank_alone)
      else $error("single input does not pick bank zero or one");

   property p_monitor;
      @(posedge CLK_IN) disable iff (!ARST_N_IN)
      s_setup_to(evbank_pkg::OFF_STATUS, 1'b0)
         |=> PREADY_OUT && PRDATA_OUT[3:0] == $past(bank);
   endproperty
   a_monitor: assert property (p_monitor)
      else $error("bank monitor read wrong");

   property p_code_range;
      @(posedge CLK_IN) disable iff (!ARST_N_IN)
      applied[0] <= evbank_pkg::ASSIGN_MAX &&
      applied[1] <= evbank_pkg::ASSIGN_MAX;
   endproperty
   a_code_range: assert property (p_code_range)
      else $error("applied assignment code out of range");

   property p_refuse_running;
      @(posedge CLK_IN) disable iff (!ARST_N_IN)
      (s_setup_to(evbank_pkg::OFF_ASSIGN_ONE, 1'b1) ##0 (|run))
         |=> PREADY_OUT && PSLVERR_OUT ##1 $stable(pending[0]);
   endproperty
   a_refuse_running: assert property (p_refuse_running)
      else $error("assignment write accepted while running");

   property p_apply_hold;
      @(posedge CLK_IN) disable iff (!ARST_N_IN)
      !soft_rst_stb |=> $stable(applied[0]) && $stable(applied[1]);
   endproperty
   a_apply_hold: assert property (p_apply_hold)
      else $error("assignment applied without soft reset");

   property p_stop_run;
      @(posedge CLK_IN) disable iff (!ARST_N_IN)
      (CE_IN && edge_seen[0] && fn[0][0] == evbank_pkg::FN_STOP_RUN &&
       fn[0][1] == evbank_pkg::FN_OFF && !cmd_stb)
         |=> run[0] == $past(lvl[0]);
   endproperty
   a_stop_run: assert property (p_stop_run)
      else $error("stop/run mode does not follow event level");

   property p_remote_gate;
      @(posedge CLK_IN) disable iff (!ARST_N_IN)
      (CE_IN && !far_sp) |=> $stable(remote);
   endproperty
   a_remote_gate: assert property (p_remote_gate)
      else $error("remote set point switched without permit");

   property p_disabled;
      @(posedge CLK_IN) disable iff (!ARST_N_IN)
      (fn[0][0] == evbank_pkg::FN_OFF && fn[0][1] == evbank_pkg::FN_OFF &&
       !cmd_stb && !BUS_BANK_STB_IN)
         |=> $stable(bank[0]) && $stable(run[0]) &&
             $stable(manual[0]) && $stable(remote[0]);
   endproperty
   a_disabled: assert property (p_disabled)
      else $error("disabled event input changed channel state");

endmodule // event_bank_select

//--- sim/event_switches.sv
// switch pair that feeds the two event pins
// assumes the bench asks for new levels; pins follow at the next edge
`timescale 1ns/10ps
module event_switches (
   // clock and reset
   input wire logic clk_in,
   input wire logic arst_n_in,
   // requested levels, bit 0 drives input one
   input wire logic [1:0] want_in,
   // pins
   output logic [1:0] pin_out
);
   // no bounce is modelled: the filter inside is only hit with clean steps
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         pin_out <= 2'h0;
      end else begin
         pin_out <= want_in;
      end
   end
endmodule // event_switches

//--- sim/event_bank_select_test.sv
// self-checking bench for the event-input bank selector
// assumes the zero-wait apb slave and filter latency of the design
`timescale 1ns/10ps
module event_bank_select_test;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic psel = 1'b0;
   logic pen = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000;
   logic [1:0] bus_bank = 2'h0;
   logic bus_stb = 1'b0;
   logic [1:0] want = 2'h0;
   logic pready;
   logic pslverr;
   logic [31:0] prdata;
   logic [1:0] pin;
   logic [3:0] bank;
   logic [1:0] run;
   logic [1:0] manual;
   logic [1:0] remote;
   logic [5:0] hi;
   int n_errors = 0;
   int tests_run = 0;

   always #10 clk = ~clk;

   event_switches SW (.clk_in(clk), .arst_n_in(arst_n), .want_in(want),
      .pin_out(pin));
   event_bank_select DUT (.CLK_IN(clk), .ARST_N_IN(arst_n), .CE_IN(1'b1),
      .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwrite),
      .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PREADY_OUT(pready),
      .PRDATA_OUT(prdata), .PSLVERR_OUT(pslverr),
      .EVENT_INPUT_ONE_IN(pin[0]), .EVENT_INPUT_TWO_IN(pin[1]),
      .BUS_BANK_IN(bus_bank), .BUS_BANK_STB_IN(bus_stb),
      .BANK_OUT(bank), .RUN_OUT(run), .MANUAL_OUT(manual),
      .REMOTE_OUT(remote));

   // ------------------------------------------------------------------
   // access tasks
   // ------------------------------------------------------------------
   task finish_test();
      $display("comparisons %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // request held from setup until the edge that samples pready high
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] r, output logic e);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      // only the watchdog ends a wait that never sees pready
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask

   task wr(input logic [11:0] a, input logic [31:0] d, input logic ee);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
      chk(32'(e), 32'(ee));
   endtask

   task rd(input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] r;
      logic e;
      apb(1'b0, a, 32'h00000000, r, e);
      chk(r, exp);
   endtask

   // new pin levels, then enough edges for sync, filter and state
   task pins(input logic [1:0] v);
      @(posedge clk);
      want <= v;
      repeat (8) @(posedge clk);
      @(negedge clk);
   endtask

   // ------------------------------------------------------------------
   // tests
   // ------------------------------------------------------------------
   initial begin
      repeat (20000) @(posedge clk);
      n_errors++;
      finish_test();
   end

   initial begin
      repeat (6) @(posedge clk);
      arst_n <= 1'b1;
      rd(evbank_pkg::OFF_ASSIGN_ONE, 32'h0);
      rd(evbank_pkg::OFF_APPLIED, 32'h0);
      wr(evbank_pkg::OFF_ASSIGN_ONE, 32'h46, 1'b1);
      wr(evbank_pkg::OFF_ASSIGN_ONE, 32'h45, 1'b0);
      wr(12'h7F0, 32'h0, 1'b1);
      wr(evbank_pkg::OFF_ASSIGN_ONE, 32'h1, 1'b0);
      wr(evbank_pkg::OFF_ASSIGN_TWO, 32'h2, 1'b0);
      rd(evbank_pkg::OFF_APPLIED, 32'h0);
      wr(evbank_pkg::OFF_CONTROL, 32'h1, 1'b0);
      rd(evbank_pkg::OFF_APPLIED, 32'h0201);
      for (int i = 0; i < 4; i++) begin
         pins(2'(i));
         chk(32'(bank), 32'(i * 5));
      end
      rd(evbank_pkg::OFF_STATUS, 32'hC0F);
      wr(12'h4C0, 32'hA5C3, 1'b0);
      rd(12'h500, 32'hA5C3);
      rd(12'h480, 32'h0);
      wr(12'h540, 32'h0, 1'b1);
      $display("bank select test done");
      wr(evbank_pkg::OFF_ASSIGN_TWO, 32'h0, 1'b0);
      wr(evbank_pkg::OFF_CONTROL, 32'h1, 1'b0);
      pins(2'h1);
      chk(32'(bank), 32'hF);
      pins(2'h0);
      chk(32'(bank), 32'h0);
      pins(2'h1);
      chk(32'(bank), 32'h5);
      @(posedge clk);
      bus_bank <= 2'h2;
      bus_stb <= 1'b1;
      @(posedge clk);
      bus_stb <= 1'b0;
      repeat (2) @(negedge clk);
      chk(32'(bank), 32'hA);
      wr(evbank_pkg::OFF_COMMAND, 32'h107, 1'b0);
      @(negedge clk);
      chk(32'(bank), 32'hE);
      $display("single input test done");
      pins(2'h0);
      for (int f = 3; f < 7; f++) begin
         wr(evbank_pkg::OFF_ASSIGN_ONE, 32'(f), 1'b0);
         wr(evbank_pkg::OFF_CONTROL, 32'h1, 1'b0);
         hi = (f == 3) ? 6'h03 : (f == 5) ? 6'h0C : 6'h00;
         pins(2'h1);
         chk(32'({remote, manual, run}), 32'(hi));
         pins(2'h0);
         chk(32'({remote, manual, run}), (f == 4) ? 32'h3 : 32'h0);
         if (f == 4) begin
            wr(evbank_pkg::OFF_ASSIGN_ONE, 32'h0, 1'b1);
            rd(evbank_pkg::OFF_ASSIGN_ONE, 32'h4);
         end
         wr(evbank_pkg::OFF_COMMAND, 32'h008, 1'b0);
         wr(evbank_pkg::OFF_COMMAND, 32'h108, 1'b0);
      end
      $display("mode test done");
      wr(evbank_pkg::OFF_ASSIGN_ONE, 32'd23, 1'b0);
      wr(evbank_pkg::OFF_CONTROL, 32'h1, 1'b0);
      pins(2'h1);
      chk(32'(run), 32'h2);
      pins(2'h0);
      wr(evbank_pkg::OFF_ASSIGN_ONE, 32'h6, 1'b0);
      wr(evbank_pkg::OFF_CONTROL, 32'h3, 1'b0);
      rd(evbank_pkg::OFF_CONTROL, 32'h2);
      pins(2'h1);
      chk(32'(remote), 32'h3);
      pins(2'h0);
      chk(32'(remote), 32'h0);
      $display("target and permit test done");
      finish_test();
   end
endmodule // event_bank_select_test
